// ---- core/bpat_node.v ----
`include "bpat_defs.vh"

// One node's arbitration, transmit and receive logic for the backplane.
// Time states advance on an internal divider; no bus slave is present.
module bpat_node #(
    parameter LINE_NUM = 4'h5,         // Own request line, 1..15
    parameter HAS_SECOND = 1'b0,       // Node answers a second code
    parameter STATE_CYC = `BPAT_STATE_CYC // Clocks per time state
) (
    input wire clk,                    // System clock
    input wire rst,                    // Async reset, active high
    input wire [15:0] req_lines_in,    // Sampled request lines
    output reg [15:0] req_lines_out,   // Request lines driven
    input wire [31:0] info_in,         // Information word in
    input wire [2:0] tag_in,           // Tag in
    input wire [4:0] code_in,          // Source/dest code in
    input wire [3:0] mask_in,          // Mask in
    input wire control_fields_parity_in, // Control parity in
    input wire info_word_parity_in,    // Word parity in
    output reg [31:0] info_out,        // Information word out
    output reg [2:0] tag_out,          // Tag out
    output reg [4:0] code_out,         // Source/dest code out
    output reg [3:0] mask_out,         // Mask out
    output reg control_fields_parity_out, // Control parity out
    output reg info_word_parity_out,   // Word parity out
    output reg drive_en,               // High while node drives path
    output reg time_state_zero,        // Pulse, start of cycle
    output reg time_state_two,         // Pulse, latches open
    output reg time_state_three,       // Pulse, latches close
    input wire xfer_req,               // Level: user wants a transfer
    input wire [1:0] xfer_kind,        // 0 read,1 write,2 isum,3 resp
    input wire [3:0] xfer_func,        // Function code for command
    input wire [27:0] xfer_addr,       // Longword address
    input wire [31:0] xfer_wdata,      // Write data or response word
    input wire [3:0] xfer_mask,        // Byte enables for write
    input wire xfer_use_second,        // Use second code
    output reg xfer_done,              // Pulse, last word driven
    output reg parity_err,             // Pulse, odd parity seen
    output reg sel_cmd,                // Pulse, command hits window
    output reg sel_rdata,              // Pulse, read data for us
    output reg [10:0] rx_offset,       // Window offset of command
    output reg [3:0] rx_func,          // Received function
    output reg [4:0] rx_code,          // Received commander code
    output reg [31:0] rx_word,         // Received word
    output reg [3:0] rx_lanes,         // Byte enables received
    output reg [1:0] rx_dtype          // 0 normal,1 corrected,2 subst
);

    // Transfer sequencing states
    localparam ST_IDLE = 2'h0;         // No request
    localparam ST_ARB = 2'h1;          // Requesting, awaiting win
    localparam ST_CMD = 2'h2;          // Driving first word
    localparam ST_DATA = 2'h3;         // Driving adjacent write word

    // Transfer kinds as coded on xfer_kind
    localparam KIND_READ = 2'h0;
    localparam KIND_WRITE = 2'h1;
    localparam KIND_ISUM = 2'h2;
    localparam KIND_RESP = 2'h3;

    // Line zero would give code 16 and line 15 code 31, both reserved,
    // so the second code is only honoured on lines 1..14
    localparam SECOND_OK = (HAS_SECOND != 0) && (LINE_NUM >= 1) &&
        (LINE_NUM <= 14);

    // Even parity: the bit makes the group's count of ones even
    function even_par32;
        input [31:0] v;
        begin
            even_par32 = ^v;
        end
    endfunction

    // Same rule over the tag, code and mask fields
    function even_par12;
        input [11:0] v;
        begin
            even_par12 = ^v;
        end
    endfunction

    reg [7:0] div_reg;                 // Clocks within a time state
    reg [1:0] phase_reg;               // Current time state
    reg [1:0] st_reg;                  // Transfer state
    reg [31:0] lat_info_reg;           // Receive latches
    reg [2:0] lat_tag_reg;
    reg [4:0] lat_code_reg;
    reg [3:0] lat_mask_reg;
    reg lat_cpar_reg;                  // Latched control parity
    reg lat_wpar_reg;                  // Latched word parity
    reg [4:0] own_code_reg;            // Code used for this transfer
    reg [1:0] kind_reg;                // Kind of this transfer

    wire state_end;
    wire [15:0] higher_mask;
    wire higher_busy;
    wire [4:0] first_code;
    wire [4:0] second_code;
    wire [27:0] win_base;

    assign state_end = (div_reg == STATE_CYC[7:0] - 8'h01);
    // Lines below our own number have higher priority
    assign higher_mask = (16'h0001 << LINE_NUM) - 16'h0001;
    assign higher_busy = |(req_lines_in & higher_mask);
    assign first_code = {1'b0, LINE_NUM[3:0]};
    assign second_code = first_code + `BPAT_CODE_SECOND_ADD;
    // Control window base selected by line number
    assign win_base = `BPAT_CTRL_BASE
        | ({24'h0, LINE_NUM[3:0]} << `BPAT_WIN_BITS);

    // Time-state sequencer: four equal states per bus cycle
    // Pulses are registered with the phase, so each is high in its state's first clock
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            div_reg <= 8'h00;
            phase_reg <= 2'h0;
            time_state_zero <= 1'b0;
            time_state_two <= 1'b0;
            time_state_three <= 1'b0;
        end else begin
            time_state_zero <= 1'b0;
            time_state_two <= 1'b0;
            time_state_three <= 1'b0;
            if (state_end) begin
                div_reg <= 8'h00;
                phase_reg <= phase_reg + 2'h1;
                time_state_zero <= (phase_reg == 2'h3);
                time_state_two <= (phase_reg == 2'h1);
                time_state_three <= (phase_reg == 2'h2);
            end else begin
                div_reg <= div_reg + 8'h01;
            end
        end
    end

    // Receive latches follow the lines in state two, freeze in three
    // Nothing downstream reads the lines directly, only these latches
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            lat_info_reg <= 32'h00000000;
            lat_tag_reg <= 3'h0;
            lat_code_reg <= 5'h00;
            lat_mask_reg <= 4'h0;
            lat_cpar_reg <= 1'b0;
            lat_wpar_reg <= 1'b0;
        end else if (phase_reg == 2'h2) begin
            lat_info_reg <= info_in;
            lat_tag_reg <= tag_in;
            lat_code_reg <= code_in;
            lat_mask_reg <= mask_in;
            lat_cpar_reg <= control_fields_parity_in;
            lat_wpar_reg <= info_word_parity_in;
        end
    end

    // Check and decode from latched values, once per cycle in state three
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            parity_err <= 1'b0;
            sel_cmd <= 1'b0;
            sel_rdata <= 1'b0;
            rx_offset <= 11'h000;
            rx_func <= 4'h0;
            rx_code <= 5'h00;
            rx_word <= 32'h00000000;
            rx_lanes <= 4'h0;
            rx_dtype <= 2'h0;
        end else begin
            parity_err <= 1'b0;
            sel_cmd <= 1'b0;
            sel_rdata <= 1'b0;
            if (time_state_three) begin
                // Idle all-zero path passes this check too
                parity_err <= (even_par12({lat_tag_reg, lat_code_reg,
                    lat_mask_reg}) != lat_cpar_reg)
                    | (even_par32(lat_info_reg) != lat_wpar_reg);
                rx_word <= lat_info_reg;
                rx_code <= lat_code_reg;
                rx_lanes <= lat_mask_reg;
                if (lat_tag_reg == `BPAT_TAG_CMD &&
                    lat_info_reg[`BPAT_ADDR_HI:`BPAT_WIN_BITS] ==
                    win_base[`BPAT_ADDR_HI:`BPAT_WIN_BITS]) begin
                    // Commands for our window: offset and function out
                    sel_cmd <= 1'b1;
                    rx_offset <= lat_info_reg[10:0];
                    rx_func <= lat_info_reg[`BPAT_FUNC_HI:`BPAT_FUNC_LO];
                end
                // Reserved code 0 keeps the idle bus from selecting us
                if (lat_tag_reg == `BPAT_TAG_RDATA &&
                    lat_code_reg != 5'h00 &&
                    (lat_code_reg == first_code || (SECOND_OK &&
                    lat_code_reg == second_code))) begin
                    // Either code may return in any order
                    sel_rdata <= 1'b1;
                    if (lat_mask_reg == `BPAT_MASK_NORMAL) begin
                        rx_dtype <= 2'h0;
                    end else if (lat_mask_reg == `BPAT_MASK_CORR) begin
                        rx_dtype <= 2'h1;
                    end else begin
                        rx_dtype <= 2'h2;
                    end
                end
            end
        end
    end

    // Arbitration and transmit sequencing
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            st_reg <= ST_IDLE;
            req_lines_out <= 16'h0000;
            info_out <= 32'h00000000;
            tag_out <= 3'h0;
            code_out <= 5'h00;
            mask_out <= 4'h0;
            control_fields_parity_out <= 1'b0;
            info_word_parity_out <= 1'b0;
            drive_en <= 1'b0;
            xfer_done <= 1'b0;
            own_code_reg <= 5'h00;
            kind_reg <= 2'h0;
        end else begin
            xfer_done <= 1'b0;
            case (st_reg)
                ST_IDLE: begin
                    // Raise own line at the start of a cycle
                    if (time_state_zero && xfer_req) begin
                        req_lines_out <= 16'h0001 << LINE_NUM;
                        kind_reg <= xfer_kind;
                        own_code_reg <= (SECOND_OK && xfer_use_second)
                            ? second_code : first_code;
                        st_reg <= ST_ARB;
                    end
                end
                ST_ARB: begin
                    // Loser keeps line up and retries in the next cycle
                    // Winner drives the path from the next cycle start
                    if (time_state_three && !higher_busy) begin
                        st_reg <= ST_CMD;
                    end
                end
                ST_CMD: begin
                    if (time_state_zero) begin
                        drive_en <= 1'b1;
                        mask_out <= 4'h0;
                        code_out <= own_code_reg;
                        // Own line drops; top line held for write only
                        req_lines_out <= (kind_reg == KIND_WRITE)
                            ? 16'h0001 : 16'h0000;
                        case (kind_reg)
                            KIND_WRITE, KIND_READ: begin
                                tag_out <= `BPAT_TAG_CMD;
                                info_out <= {xfer_func, xfer_addr};
                                mask_out <= xfer_mask;
                            end
                            KIND_ISUM: begin
                                tag_out <= `BPAT_TAG_ISUM;
                                info_out <= {24'h0, xfer_wdata[7:4],
                                    4'h0};
                            end
                            default: begin
                                tag_out <= `BPAT_TAG_RDATA;
                                info_out <= xfer_wdata;
                            end
                        endcase
                        if (kind_reg == KIND_WRITE) begin
                            st_reg <= ST_DATA;
                        end else begin
                            xfer_done <= 1'b1;
                            st_reg <= ST_IDLE;
                        end
                    end
                end
                ST_DATA: begin
                    // Write data in the very next cycle
                    // Line zero drops here, so only one extra cycle is held
                    if (time_state_zero) begin
                        tag_out <= `BPAT_TAG_WDATA;
                        info_out <= xfer_wdata;
                        mask_out <= xfer_mask;
                        req_lines_out <= 16'h0000;
                        xfer_done <= 1'b1;
                        st_reg <= ST_IDLE;
                    end
                end
                default: st_reg <= ST_IDLE;
            endcase
            // Release path at the cycle start after the last word (one cycle, two for a write)
            if (time_state_zero && st_reg != ST_CMD &&
                st_reg != ST_DATA) begin
                drive_en <= 1'b0;
                info_out <= 32'h00000000;
                tag_out <= 3'h0;
                code_out <= 5'h00;
                mask_out <= 4'h0;
            end
            // Parity tracks whatever the outputs will carry
            // It lags the fields by one clock; receivers latch far later
            control_fields_parity_out <=
                even_par12({tag_out, code_out, mask_out});
            info_word_parity_out <= even_par32(info_out);
        end
    end

endmodule // bpat_node

// ---- core/bpat_defs.vh ----
// What this block does
// - Sixteen request lines, line zero highest priority
// - Processor lowest, no line; others lines 15..1
// - Top line only holds adjacent cycle sequences
// - Request at cycle start, sample higher late
// - Write exchange asserts top line to hold cycles
// - Loser keeps request, rechecks each cycle
// - Even parity over control fields and word
// - Check parity every cycle, flag odd parity
// - Tag 011 is command/address with commander code
// - 28-bit longword address, upper half control space
// - Decode 2048-longword window set by line number
// - Tag 000 read data; mask gives data type
// - Idle pattern never selects this node
// - Tag 101 write data follows command immediately
// - Tag 110 interrupt summary, level bits 7..4
// - Interrupt response is sent with tag 000
// - Tag 111 diagnostic; 001,010,100 never generated
// - Source code equals own request line number
// - Second code is first plus 16
// - Codes 16, 31, 0 reserved
// - Mask bits enable byte lanes
// - Read mask 0010..1111 means substitute data
// - Four time states per cycle; 50 ns / 20 ns rounds down to 2 clocks, so 40 ns each
// - Check and decode only latched values
`ifndef BPAT_DEFS_VH
`define BPAT_DEFS_VH
`define BPAT_TAG_RDATA 3'h0
`define BPAT_TAG_CMD 3'h3
`define BPAT_TAG_WDATA 3'h5
`define BPAT_TAG_ISUM 3'h6
`define BPAT_TAG_DIAG 3'h7
`define BPAT_MASK_NORMAL 4'h0
`define BPAT_MASK_CORR 4'h1
`define BPAT_MASK_SUBST 4'h2
`define BPAT_CTRL_BASE 28'h8000000
`define BPAT_WIN_BITS 11
`define BPAT_CODE_UNITPROC 5'h10
`define BPAT_CODE_DIAG 5'h1F
`define BPAT_CODE_SECOND_ADD 5'h10
`define BPAT_LVL_HI 7
`define BPAT_LVL_LO 4
`define BPAT_ADDR_HI 27
`define BPAT_FUNC_HI 31
`define BPAT_FUNC_LO 28
`define BPAT_STATE_NS 50
`define BPAT_CLK_NS 20
`define BPAT_STATE_CYC ((`BPAT_STATE_NS) / (`BPAT_CLK_NS))
`endif

// ---- sim/bpat_node_sva.sv ----
module bpat_node_sva #(
    parameter LINE_NUM = 4'h5 // Own request line
) (
    input wire clk, // Clock
    input wire rst, // Reset
    input wire [15:0] req_lines_in, // Lines seen
    input wire [15:0] req_lines_out, // Lines driven
    input wire [31:0] info_out, // Word out
    input wire [2:0] tag_out, // Tag out
    input wire [4:0] code_out, // Code out
    input wire [3:0] mask_out, // Mask out
    input wire control_fields_parity_out, // Control parity
    input wire info_word_parity_out, // Word parity
    input wire drive_en, // Owns path
    input wire time_state_two, // Latches open
    input wire time_state_three, // Latches close
    input wire parity_err, // Odd parity seen
    input wire sel_cmd // Window hit
);
    timeunit 1ns;
    timeprecision 1ns;
    // Lines that outrank ours
    wire [15:0] hi_lines = (16'h1 << LINE_NUM) - 16'h1;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    idle_zero_a: assert property (
        !drive_en |-> {info_out, tag_out, code_out, mask_out} == 44'h0)
        else $error("path driven while not owner");
    ctl_parity_a: assert property (
        drive_en && time_state_two |->
        control_fields_parity_out == ^{tag_out, code_out, mask_out})
        else $error("control parity odd");
    word_parity_a: assert property (
        drive_en && time_state_two |-> info_word_parity_out == ^info_out)
        else $error("word parity odd");
    tag_legal_a: assert property (
        drive_en |-> tag_out inside {3'h0, 3'h3, 3'h5, 3'h6})
        else $error("unused tag generated");
    own_code_a: assert property (
        drive_en && tag_out == 3'h3 |->
        code_out == LINE_NUM || code_out == LINE_NUM + 16)
        else $error("command code not own");
    isum_mask_a: assert property (
        drive_en && tag_out == 3'h6 |-> mask_out == 4'h0)
        else $error("summary mask not zero");
    wdata_next_a: assert property (
        $rose(drive_en) && tag_out == 3'h3 && req_lines_out[0] |->
        ##8 drive_en && tag_out == 3'h5)
        else $error("write data not in next cycle");
    win_drop_a: assert property (
        $rose(drive_en) |-> !req_lines_out[LINE_NUM])
        else $error("own line kept after win");
    lose_hold_a: assert property (
        time_state_three && req_lines_out[LINE_NUM] &&
        |(req_lines_in & hi_lines) |=>
        (req_lines_out[LINE_NUM] && !drive_en)[*6])
        else $error("loser dropped line or drove");
    perr_time_a: assert property (
        parity_err |-> time_state_three || $past(time_state_three))
        else $error("parity flag off its time state");
    cover property (drive_en && tag_out == 3'h5);
    cover property (parity_err);
    cover property (sel_cmd);
endmodule // bpat_node_sva

bind bpat_node bpat_node_sva #(.LINE_NUM(LINE_NUM)) chk_u (
    .clk(clk), .rst(rst), .req_lines_in(req_lines_in),
    .req_lines_out(req_lines_out), .info_out(info_out),
    .tag_out(tag_out), .code_out(code_out), .mask_out(mask_out),
    .control_fields_parity_out(control_fields_parity_out),
    .info_word_parity_out(info_word_parity_out), .drive_en(drive_en),
    .time_state_two(time_state_two), .time_state_three(time_state_three),
    .parity_err(parity_err), .sel_cmd(sel_cmd));

// ---- sim/bpat_far_nodes.sv ----
// Other nodes on the path: they hold request lines and send one frame
module bpat_far_nodes (
    input wire clk, // Clock
    input wire rst, // Reset
    input wire ts0, // Cycle start pulse
    input wire ld, // Frame pending
    input wire [15:0] ld_req, // Lines to hold
    input wire [43:0] ld_word, // Tag, code, mask, word
    input wire ld_bad, // Spoil control parity
    output reg [15:0] req_out, // Lines of other nodes
    output reg [43:0] word_out, // Path fields
    output reg [1:0] par_out // Control and word parity
);
    timeunit 1ns;
    timeprecision 1ns;
    // Everything changes only at cycle start, held one whole cycle
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            req_out <= 16'h0;
            word_out <= 44'h0;
            par_out <= 2'h0;
        end else if (ts0) begin
            req_out <= ld_req;
            word_out <= ld ? ld_word : 44'h0;
            par_out <= ld ? {^ld_word[43:32] ^ ld_bad, ^ld_word[31:0]}
                : 2'h0;
        end
    end
endmodule // bpat_far_nodes

// ---- sim/tb_backplane_arbitration_transfer.sv ----
module tb_backplane_arbitration_transfer;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct {logic [43:0] w; logic [43:0] care;} bpat_exp_t;
    logic clk = 0, rst = 1, xfer_req = 0, xfer_use_second = 0, ld = 0;
    logic ld_bad = 0;
    logic [1:0] xfer_kind = 0;
    logic [3:0] xfer_func = 0, xfer_mask = 0, m;
    logic [27:0] xfer_addr = 0;
    logic [31:0] xfer_wdata = 0, r;
    logic [15:0] ld_req = 0;
    logic [43:0] ld_word = 0;
    wire [15:0] req_lines_out, pr;
    wire [43:0] pw;
    wire [31:0] info_out, rx_word;
    wire [2:0] tag_out;
    wire [4:0] code_out, rx_code;
    wire [3:0] mask_out, rx_func, rx_lanes;
    wire [10:0] rx_offset;
    wire [1:0] rx_dtype, pp;
    wire cpo, wpo, drive_en, ts0, ts2, ts3, xfer_done, parity_err;
    wire sel_cmd, sel_rdata;
    integer seed, err_total = 0, tests_run = 0, i;
    bpat_exp_t pq[$], rq[$]; // Path words and receive events awaited
    always #10 clk = ~clk;
    bpat_node #(.LINE_NUM(4'h5), .HAS_SECOND(1'b1), .STATE_CYC(2)) dut_u (
        .clk(clk), .rst(rst), .req_lines_in(pr | req_lines_out),
        .req_lines_out(req_lines_out), .info_in(pw[31:0] | info_out),
        .tag_in(pw[43:41] | tag_out), .code_in(pw[40:36] | code_out),
        .mask_in(pw[35:32] | mask_out), .info_word_parity_in(pp[0] | wpo),
        .control_fields_parity_in(pp[1] | cpo), .info_out(info_out),
        .tag_out(tag_out), .code_out(code_out), .mask_out(mask_out),
        .control_fields_parity_out(cpo), .info_word_parity_out(wpo),
        .drive_en(drive_en), .time_state_zero(ts0), .time_state_two(ts2),
        .time_state_three(ts3), .xfer_req(xfer_req), .xfer_kind(xfer_kind),
        .xfer_func(xfer_func), .xfer_addr(xfer_addr), .xfer_mask(xfer_mask),
        .xfer_wdata(xfer_wdata), .xfer_use_second(xfer_use_second),
        .xfer_done(xfer_done), .parity_err(parity_err), .sel_cmd(sel_cmd),
        .sel_rdata(sel_rdata), .rx_offset(rx_offset), .rx_func(rx_func),
        .rx_code(rx_code), .rx_word(rx_word), .rx_lanes(rx_lanes),
        .rx_dtype(rx_dtype));
    bpat_far_nodes far_u (.clk(clk), .rst(rst), .ts0(ts0), .ld(ld),
        .ld_req(ld_req), .ld_word(ld_word), .ld_bad(ld_bad),
        .req_out(pr), .word_out(pw), .par_out(pp));
    task automatic flag(input string msg);
        err_total++;
        $display("unexpected at %0t: %s", $time, msg);
    endtask
    // Only the fields marked in care are judged
    task automatic cmp_path(input bpat_exp_t e, input logic [43:0] a);
        tests_run++;
        if (((a ^ e.w) & e.care) !== 44'h0) flag("path word differs");
    endtask
    task automatic cmp_rx(input bpat_exp_t e, input logic [43:0] a);
        tests_run++;
        if (a !== e.w) flag("receive result differs");
    endtask
    // Ask the node for one transfer and note the words it must drive
    task automatic dut_xfer(input logic [1:0] k, input logic sec);
        logic [4:0] c;
        int n;
        c = sec ? 5'h15 : 5'h05;
        n = 0;
        @(posedge clk);
        #2;
        {xfer_func, xfer_addr} = $random(seed);
        xfer_addr[27] = 1'b0;
        xfer_wdata = $random(seed);
        xfer_mask = $random(seed);
        xfer_kind = k;
        xfer_use_second = sec;
        if (k == 2'h2) pq.push_back('{{3'h6, c, 4'h0, xfer_wdata},
            {12'hFFF, 24'h0, 8'hF0}});
        else if (k == 2'h3) pq.push_back('{{12'h0, xfer_wdata},
            {3'h7, 9'h0, 32'hFFFFFFFF}});
        else pq.push_back('{{3'h3, c, xfer_mask, xfer_func, xfer_addr},
            {8'hFF, k[0] ? 4'hF : 4'h0, 32'hFFFFFFFF}});
        if (k == 2'h1) pq.push_back('{{12'hA00, xfer_wdata},
            {3'h7, 9'h0, 32'hFFFFFFFF}});
        xfer_req = 1'b1;
        while (xfer_done !== 1'b1 && n < 300) begin
            @(posedge clk);
            #1;
            n++;
        end
        if (n >= 300) flag("transfer never done");
        #1;
        xfer_req = 1'b0;
    endtask
    // Other nodes put one frame on the path for one whole cycle
    task automatic send(input logic [43:0] w, input logic b,
        input logic [15:0] q);
        @(posedge clk iff ts0 === 1'b1);
        #2;
        ld = 1'b1;
        ld_word = w;
        ld_bad = b;
        ld_req = q;
        @(posedge clk iff ts0 === 1'b1);
        #2;
        ld = 1'b0;
    endtask
    task automatic complete_run;
        if (pq.size() + rq.size() != 0) flag("results never seen");
        $display("tests_run=%0d err_total=%0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // Watch outputs; own frames echo back, so receive is judged off-drive
    always @(posedge clk) begin
        if (!rst && drive_en === 1'b1 && ts2 === 1'b1) begin
            if (pq.size() == 0) flag("path word not awaited");
            else cmp_path(pq.pop_front(),
                {tag_out, code_out, mask_out, info_out});
        end
        if (!rst && drive_en !== 1'b1
            && (sel_cmd | sel_rdata | parity_err) === 1'b1) begin
            if (rq.size() == 0) flag("receive event not awaited");
            else cmp_rx(rq.pop_front(), sel_cmd ? {20'h1,
                rx_offset, rx_func, rx_code, rx_lanes} : sel_rdata ?
                {10'h2, rx_word, rx_dtype} : 44'h3);
        end
    end
    initial begin
        #200000;
        flag("watchdog expired");
        complete_run();
    end
    initial begin
        seed = 35;
        repeat (8) @(posedge clk);
        #2;
        rst = 1'b0;
        for (i = 0; i < 4; i++) dut_xfer(i[1:0], 1'b0);
        dut_xfer(2'h0, 1'b1);
        send(44'h0, 1'b0, 16'h0004);
        fork
            dut_xfer(2'h1, 1'b0);
            begin
                repeat (3) send(44'h0, 1'b0, 16'h0001);
                send(44'h0, 1'b0, 16'h0000);
            end
        join
        for (i = 0; i < 6; i++) begin
            r = $random(seed);
            rq.push_back('{{20'h1, r[10:0], r[31:28], 5'h07, r[15:12]},
                {44{1'b1}}});
            send({3'h3, 5'h07, r[15:12], r[31:28], 13'h1000, 4'h5,
                r[10:0]}, 1'b0, 16'h0);
            send({3'h3, 5'h07, 4'hF, r[31:28], 13'h1000, 4'h6,
                r[10:0]}, 1'b0, 16'h0);
        end
        for (i = 0; i < 16; i++) begin
            r = $random(seed);
            m = i[3:0];
            rq.push_back('{{10'h2, r, m < 4'h3 ? m[1:0] : 2'h2},
                {44{1'b1}}});
            send({3'h0, i[0] ? 5'h15 : 5'h05, m, r}, 1'b0, 16'h0);
        end
        send({12'h0, r}, 1'b0, 16'h0);
        rq.push_back('{44'h3, {44{1'b1}}});
        send({12'h0, r}, 1'b1, 16'h0);
        repeat (24) @(posedge clk);
        complete_run();
    end
endmodule // tb_backplane_arbitration_transfer
